// file: arb_if.sv
// Request and grant bundle between the vectoring top and its arbiter
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
  logic [vector_pkg::NUM_SRC-1:0] reqs;
  logic                           grantValid;
  logic [vector_pkg::SRC_W-1:0]   grantIdx;
  modport requester (output reqs, input grantValid, input grantIdx);
  modport arbiter   (input reqs, output grantValid, output grantIdx);
endinterface
`default_nettype wire

// file: core_model.sv
// Processor core stand-in that acknowledges pending interrupts
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic       mclk,      // System clock
  input  wire logic       ackOn,     // Acknowledges allowed
  input  wire logic [3:0] ackDelay,  // Cycles to wait before acking
  input  wire logic       intReq,    // Request pending from the block
  input  wire logic       ackValid,  // Vector answer pulse
  output var  logic       intAck,    // Acknowledge pulse
  output var  int         nAck       // Answers seen so far
);
  int waitCnt;
  initial begin
    intAck = 1'b0;
    nAck = 0;
    waitCnt = 0;
  end
  // A request that drops while waiting restarts the wait, so no stale ack
  always @(negedge mclk) begin
    if (intAck) begin
      intAck <= 1'b0;
      waitCnt <= 0;
    end else if (ackOn && intReq === 1'b1) begin
      if (waitCnt >= ackDelay)
        intAck <= 1'b1;
      else
        waitCnt <= waitCnt + 1;
    end else
      waitCnt <= 0;
  end
  always @(posedge mclk)
    if (ackValid === 1'b1)
      nAck <= nAck + 1;
endmodule // core_model
`default_nettype wire

// file: interrupt_vectoring.sv
// Fixed-priority interrupt arbitration and vector generation
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none
module interrupt_vectoring #(
  parameter logic [15:0] DEFAULT_HANDLER = vector_pkg::HANDLER_RESET
) (
  input  wire logic        mclk,          // System clock, 250 MHz
  input  wire logic        rstn,          // Async reset, active low
  input  wire logic [15:0] ioAddr,        // Core I/O address
  input  wire logic [7:0]  ioWrData,      // Core I/O write data
  input  wire logic        ioWr,          // I/O write strobe
  input  wire logic        ioRd,          // I/O read strobe
  output logic      [7:0]  ioRdData,      // Read data, one cycle after ioRd
  input  wire logic        intEnable,     // Core maskable enable
  input  wire logic        intAck,        // Core acknowledge pulse
  input  wire logic        trapEvent,     // Illegal opcode pulse from core
  input  wire logic        nmiN,          // NMI pin, falling edge
  input  wire logic        ext0ReqN,      // Level 0 pin, active low
  input  wire logic        ext2ReqN,      // Level 2 pin, active low
  input  wire logic        powerFailN,    // Supervisor warning, active low
  input  wire logic [7:0]  level0Byte,    // Vector byte from level 0 device
  input  wire logic [8:0]  periphReq,     // Timers, DMA, serial on bits 7..1; bits 0 and 8 unused
  output logic             intReq,        // Request pending toward the core
  output logic             ackValid,      // Vector answer pulse
  output logic      [3:0]  ackSource,     // Source index granted
  output logic      [15:0] vectorAddr,    // Vector address
  output logic      [15:0] handlerAddr    // Slot contents, zero if no slot
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NPIN = 4;
  logic [NPIN-1:0] pinRaw, syncA_q, syncB_q;
  assign pinRaw = {~powerFailN, ~ext2ReqN, ~ext0ReqN, ~nmiN};
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : gSync
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          syncA_q[g] <= 1'b0;
          syncB_q[g] <= 1'b0;
        end else begin
          syncA_q[g] <= pinRaw[g];
          syncB_q[g] <= syncA_q[g];
        end
      end
    end
  endgenerate
  logic nmiLvl, ext0Lvl, ext2Lvl, pfLvl, nmiPrev_q;
  assign nmiLvl  = syncB_q[0];
  assign ext0Lvl = syncB_q[1];
  assign ext2Lvl = syncB_q[2];
  assign pfLvl   = syncB_q[3];
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  trapCtrl_q, vecLow_q, pageBase_q;
  logic [1:0]  l0Mode_q;
  logic [15:0] slot_q [vector_pkg::NUM_SLOT];
  logic        isSlotAddr;
  logic [3:0]  slotSel;
  assign isSlotAddr = (ioAddr >= vector_pkg::ADDR_SLOT_BASE) &&
    (ioAddr < vector_pkg::ADDR_SLOT_BASE + 16'(2 * vector_pkg::NUM_SLOT));
  assign slotSel = 4'((ioAddr - vector_pkg::ADDR_SLOT_BASE) >> 1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trapCtrl_q <= vector_pkg::ITC_RESET;
      vecLow_q   <= vector_pkg::VEC_LOW_RESET;
      pageBase_q <= vector_pkg::PAGE_RESET;
      l0Mode_q   <= 2'(vector_pkg::L0_DEVICE_BYTE);
    end else if (ioWr) begin
      case (ioAddr)
        vector_pkg::ADDR_TRAP_CTRL: trapCtrl_q <= ioWrData;
        vector_pkg::ADDR_VEC_LOW:   vecLow_q   <= ioWrData;
        vector_pkg::ADDR_PAGE_BASE: pageBase_q <= ioWrData;
        vector_pkg::ADDR_L0_MODE:   l0Mode_q   <= ioWrData[1:0];
        default: ;
      endcase
    end
  end

  // Byte-wide writes into two-byte slots, low byte at even address
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < vector_pkg::NUM_SLOT; i++)
        slot_q[i] <= DEFAULT_HANDLER;
    end else if (ioWr && isSlotAddr) begin
      if (ioAddr[0])
        slot_q[slotSel][15:8] <= ioWrData;
      else
        slot_q[slotSel][7:0]  <= ioWrData;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ioRdData <= 8'h00;
    end else if (ioRd) begin
      if (isSlotAddr)
        ioRdData <= ioAddr[0] ? slot_q[slotSel][15:8] : slot_q[slotSel][7:0];
      else begin
        case (ioAddr)
          vector_pkg::ADDR_TRAP_CTRL: ioRdData <= trapCtrl_q;
          vector_pkg::ADDR_VEC_LOW:   ioRdData <= vecLow_q;
          vector_pkg::ADDR_PAGE_BASE: ioRdData <= pageBase_q;
          vector_pkg::ADDR_L0_MODE:   ioRdData <= {6'h00, l0Mode_q};
          vector_pkg::ADDR_PF_STATE:  ioRdData <= {7'h00, pfLvl};
          default:                    ioRdData <= 8'h00;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Pending sources
  logic trapPend_q, nmiPend_q, ackTake;
  logic [3:0] winIdx;
  arb_if arb ();
  priority_arbiter uArb (.arb(arb.arbiter));
  assign winIdx  = arb.grantIdx;
  assign ackTake = intAck && arb.grantValid;

  // Set wins over the clear from an acknowledge in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trapPend_q <= 1'b0;
      nmiPend_q  <= 1'b0;
      nmiPrev_q  <= 1'b0;
    end else begin
      nmiPrev_q <= nmiLvl;
      if (trapEvent)
        trapPend_q <= 1'b1;
      else if (ackTake && winIdx == vector_pkg::SRC_TRAP)
        trapPend_q <= 1'b0;
      if (nmiLvl && !nmiPrev_q)
        nmiPend_q <= 1'b1;
      else if (ackTake && winIdx == vector_pkg::SRC_NMI)
        nmiPend_q <= 1'b0;
    end
  end

  // Maskable sources need the core enable; trap and NMI bypass it
  // Only bits 7..1 carry sources, timer 0 up to serial B
  assign arb.reqs = {
    periphReq[7:1] & {7{intEnable}},
    ext2Lvl & trapCtrl_q[vector_pkg::ITC_EN2] & intEnable,
    pfLvl   & trapCtrl_q[vector_pkg::ITC_EN1] & intEnable,
    ext0Lvl & trapCtrl_q[vector_pkg::ITC_EN0] & intEnable,
    nmiPend_q,
    trapPend_q };
  //////////////////////////////////////////////////////////////////////////////
  // Vector formation
  function automatic logic [4:0] slotOffset(input logic [3:0] src);
    case (src)
      vector_pkg::SRC_LEVEL1: slotOffset = vector_pkg::OFS_LEVEL1;
      vector_pkg::SRC_LEVEL2: slotOffset = vector_pkg::OFS_LEVEL2;
      vector_pkg::SRC_TIMER0: slotOffset = vector_pkg::OFS_TIMER0;
      vector_pkg::SRC_TIMER1: slotOffset = vector_pkg::OFS_TIMER1;
      vector_pkg::SRC_DMA_A:  slotOffset = vector_pkg::OFS_DMA_A;
      vector_pkg::SRC_DMA_B:  slotOffset = vector_pkg::OFS_DMA_B;
      vector_pkg::SRC_CSIO:   slotOffset = vector_pkg::OFS_CSIO;
      vector_pkg::SRC_SER_A:  slotOffset = vector_pkg::OFS_SER_A;
      vector_pkg::SRC_SER_B:  slotOffset = vector_pkg::OFS_SER_B;
      default:                slotOffset = 5'h00;
    endcase
  endfunction

  logic [15:0] vecD, handD;
  logic        hasSlot;
  assign hasSlot = winIdx >= vector_pkg::SRC_FIRST_SLOT;
  always_comb begin
    handD = 16'h0000;
    case (winIdx)
      vector_pkg::SRC_TRAP: vecD = vector_pkg::TRAP_ENTRY;
      vector_pkg::SRC_NMI:  vecD = vector_pkg::NMI_ENTRY;
      vector_pkg::SRC_LEVEL0: begin
        case (vector_pkg::level0_mode_type'(l0Mode_q))
          vector_pkg::L0_FIXED_RESTART: vecD = vector_pkg::RESTART_ENTRY;
          vector_pkg::L0_PAGE_BYTE:     vecD = {pageBase_q, level0Byte};
          default:                      vecD = {8'h00, level0Byte};
        endcase
      end
      default: begin
        vecD  = {pageBase_q, vecLow_q[vector_pkg::VEC_LOW_MSB:
                 vector_pkg::VEC_LOW_LSB], slotOffset(winIdx)};
        handD = slot_q[4'(winIdx - vector_pkg::SRC_FIRST_SLOT)];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      intReq      <= 1'b0;
      ackValid    <= 1'b0;
      ackSource   <= 4'h0;
      vectorAddr  <= 16'h0000;
      handlerAddr <= 16'h0000;
    end else begin
      intReq   <= arb.grantValid && !ackTake;
      ackValid <= ackTake;
      if (ackTake) begin
        ackSource   <= winIdx;
        vectorAddr  <= vecD;
        handlerAddr <= hasSlot ? handD : 16'h0000;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence sAckTaken; intAck && arb.grantValid; endsequence
  sequence sAnswer;   ackValid && ackSource == $past(winIdx); endsequence

  a_ack_answers: assert property (sAckTaken |=> sAnswer)
    else $error("acknowledge not answered with winner");
  a_trap_wins: assert property (trapPend_q |-> winIdx == 4'h0)
    else $error("trap not highest");
  a_order_kept: assert property (arb.reqs[1] && !arb.reqs[0]
    |-> winIdx == 4'h1) else $error("nmi order wrong");
  a_level1_gate: assert property (!trapCtrl_q[1] |->
    !(arb.grantValid && winIdx == 4'h3)) else $error("level 1 leaked");
  a_level1_slot: assert property (sAckTaken ##0 winIdx == 4'h3
    |=> vectorAddr[4:0] == 5'h00) else $error("level 1 offset");
  a_serb_slot: assert property (sAckTaken ##0 winIdx == 4'hB
    |=> vectorAddr[4:0] == 5'h10 && vectorAddr[15:8] == $past(pageBase_q))
    else $error("serial b offset or page");
  a_timer_slot: assert property (sAckTaken ##0 winIdx == 4'h5
    |=> vectorAddr[4:0] == 5'h04) else $error("timer 0 offset");
  a_even_slot: assert property (ackValid && ackSource > 4'h2
    |-> !vectorAddr[0]) else $error("odd slot address");
  a_pf_readback: assert property (ioRd && ioAddr == 16'hA000
    |=> ioRdData[0] == $past(pfLvl)) else $error("power fail state");
  a_ctrl_write: assert property (ioWr && ioAddr == 16'h0034
    |=> trapCtrl_q == $past(ioWrData)) else $error("control write lost");
endmodule // interrupt_vectoring
`default_nettype wire

// file: prioritized_interrupt_vectoring_bench.sv
// Self-checking bench for the interrupt vectoring block
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_vectoring_bench;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] ioAddr, vectorAddr, handlerAddr;
  logic [7:0]  ioWrData, ioRdData, level0Byte, page, vecLow, d;
  logic        ioWr, ioRd, intEnable, intAck, trapEvent, nmiN, pres;
  logic        ext0ReqN, ext2ReqN, powerFailN, intReq, ackValid, ackOn;
  logic [8:0]  periphReq;
  logic [3:0]  ackSource, ackDelay;
  logic [15:0] hnd [9];
  logic [9:0]  mask;
  int          nAck, old, seed;
  int          nMismatch = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  // Slot offsets within the vector page, level 1 first
  localparam logic [4:0] OFS [9] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08,
                                     5'h0A, 5'h0C, 5'h0E, 5'h10};
  localparam logic [15:0] RD_ADDR [6] = '{16'h0034, 16'h0033, 16'h0035,
                                          16'h0036, 16'h0037, 16'hA000};
  localparam logic [7:0]  RD_EXP [6] = '{8'h01, 8'h00, 8'h00,
                                         8'h00, 8'h00, 8'h00};
  always #2 mclk = ~mclk;
  interrupt_vectoring u_interrupt_vectoring (
    .mclk(mclk), .rstn(rstn), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .intEnable(intEnable),
    .intAck(intAck), .trapEvent(trapEvent), .nmiN(nmiN),
    .ext0ReqN(ext0ReqN), .ext2ReqN(ext2ReqN), .powerFailN(powerFailN),
    .level0Byte(level0Byte), .periphReq(periphReq), .intReq(intReq),
    .ackValid(ackValid), .ackSource(ackSource), .vectorAddr(vectorAddr),
    .handlerAddr(handlerAddr));
  core_model u_core_model (
    .mclk(mclk), .ackOn(ackOn), .ackDelay(ackDelay), .intReq(intReq),
    .ackValid(ackValid), .intAck(intAck), .nAck(nAck));
  //////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict;
    $display("Checks %0d, mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic ioWrite(input logic [15:0] a, input logic [7:0] v);
    @(negedge mclk);
    ioAddr = a;
    ioWrData = v;
    ioWr = 1'b1;
    @(negedge mclk);
    ioWr = 1'b0;
  endtask
  task automatic ioRead(input logic [15:0] a);
    @(negedge mclk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge mclk);
    ioRd = 1'b0;
    d = ioRdData;
  endtask
  function automatic logic [15:0] vecOf(input logic [3:0] s);
    if (s == 4'h0)
      return 16'h0000;
    if (s == 4'h1)
      return 16'h0066;
    return {page, vecLow[7:5], OFS[s - 4'h3]};
  endfunction
  // Lets the core acknowledge once, then compares the answer
  task automatic waitAck(input logic [3:0] src, input logic [15:0] v);
    old = nAck;
    ackOn = 1'b1;
    for (int n = 0; n < 80 && nAck == old; n++)
      @(negedge mclk);
    ackOn = 1'b0;
    check({15'h0000, nAck != old}, 16'h0001);
    check({12'h000, ackSource}, {12'h000, src});
    check(vectorAddr, v);
    check(handlerAddr, src >= 4'h3 ? hnd[src - 4'h3] : 16'h0000);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      nMismatch++;
      giveVerdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(25124);
    {ioAddr, ioWrData, ioWr, ioRd, trapEvent, level0Byte, ackOn} = '0;
    {intEnable, nmiN, ext0ReqN, ext2ReqN, powerFailN} = 5'h1F;
    periphReq = 9'h000;
    ackDelay = 4'h0;
    repeat (4) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ioRead(RD_ADDR[i]);
      check({8'h00, d}, {8'h00, RD_EXP[i]});
    end
    page = 8'($urandom);
    vecLow = 8'($urandom);
    ioWrite(16'h0035, page);
    ioWrite(16'h0033, vecLow);
    // Bytes of each slot land independently, low byte first
    for (int i = 0; i < 18; i++) begin
      d = 8'($urandom);
      ioWrite(16'h0040 + 16'(i), d);
      if (i[0])
        hnd[i / 2][15:8] = d;
      else
        hnd[i / 2][7:0] = d;
    end
    ioWrite(16'h0034, 8'h07);
    for (int b = 1; b < 8; b++) begin
      ackDelay = 4'($urandom % 4);
      periphReq = 9'h000;
      periphReq[b] = 1'b1;
      periphReq[0] = 1'($urandom);
      waitAck(4'(b + 4), vecOf(4'(b + 4)));
      periphReq = 9'h000;
    end
    ext2ReqN = 1'b0;
    waitAck(4'h4, vecOf(4'h4));
    ext2ReqN = 1'b1;
    repeat (6) @(negedge mclk);
    ioWrite(16'h0034, 8'h05);
    powerFailN = 1'b0;
    repeat (8) @(negedge mclk);
    check({15'h0000, intReq}, 16'h0000);
    ioRead(16'hA000);
    check({8'h00, d}, 16'h0001);
    ioWrite(16'h0034, 8'h07);
    waitAck(4'h3, vecOf(4'h3));
    ioWrite(16'h0034, 8'h05);
    repeat (8) @(negedge mclk);
    check({15'h0000, intReq}, 16'h0000);
    powerFailN = 1'b1;
    for (int m = 0; m < 3; m++) begin
      ioWrite(16'h0036, 8'(m));
      level0Byte = 8'($urandom);
      ext0ReqN = 1'b0;
      waitAck(4'h2, m == 0 ? {8'h00, level0Byte} :
              m == 1 ? 16'h0038 : {page, level0Byte});
      ext0ReqN = 1'b1;
      repeat (6) @(negedge mclk);
    end
    intEnable = 1'b0;
    periphReq = 9'h002;
    repeat (10) @(negedge mclk);
    check({15'h0000, intReq}, 16'h0000);
    periphReq = 9'h000;
    intEnable = 1'b1;
    // Several sources at once; each winner is dropped after its answer
    for (int k = 0; k < 24; k++) begin
      mask = (k == 0) ? 10'h3FF : 10'($urandom);
      ackDelay = 4'(4 + $urandom % 4);
      periphReq[7:1] = mask[6:0];
      ext2ReqN = ~mask[7];
      trapEvent = mask[8];
      nmiN = ~mask[9];
      @(negedge mclk);
      trapEvent = 1'b0;
      repeat (5) @(negedge mclk);
      for (int s = 0; s < 12; s++) begin
        pres = s == 0 ? mask[8] : s == 1 ? mask[9] : s == 4 ? mask[7] :
               s >= 5 ? mask[s - 5] : 1'b0;
        if (pres) begin
          waitAck(4'(s), vecOf(4'(s)));
          if (s == 4)
            ext2ReqN = 1'b1;
          if (s >= 5)
            periphReq[s - 4] = 1'b0;
        end
      end
      nmiN = 1'b1;
      repeat (6) @(negedge mclk);
    end
    giveVerdict();
  end
endmodule // prioritized_interrupt_vectoring_bench
`default_nettype wire

// file: priority_arbiter.sv
// Fixed-priority arbiter: lowest index wins
`timescale 1ns/100ps
`default_nettype none
module priority_arbiter (
  arb_if.arbiter arb   // Pending requests in, single grant out
);
  // Scanning downward leaves the lowest pending index standing
  always_comb begin
    arb.grantValid = 1'b0;
    arb.grantIdx   = '0;
    for (int i = vector_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (arb.reqs[i]) begin
        arb.grantValid = 1'b1;
        arb.grantIdx   = vector_pkg::SRC_W'(i);
      end
    end
  end
endmodule // priority_arbiter
`default_nettype wire

// file: vector_pkg.sv
// Constants shared by the interrupt vectoring block
`default_nettype none
package vector_pkg;
  // Sources, in fixed priority order, index 0 highest
  localparam int NUM_SRC      = 12;
  localparam int SRC_W        = 4;
  localparam logic [3:0] SRC_TRAP   = 4'h0;
  localparam logic [3:0] SRC_NMI    = 4'h1;
  localparam logic [3:0] SRC_LEVEL0 = 4'h2;
  localparam logic [3:0] SRC_LEVEL1 = 4'h3;
  localparam logic [3:0] SRC_LEVEL2 = 4'h4;
  localparam logic [3:0] SRC_TIMER0 = 4'h5;
  localparam logic [3:0] SRC_TIMER1 = 4'h6;
  localparam logic [3:0] SRC_DMA_A  = 4'h7;
  localparam logic [3:0] SRC_DMA_B  = 4'h8;
  localparam logic [3:0] SRC_CSIO   = 4'h9;
  localparam logic [3:0] SRC_SER_A  = 4'hA;
  localparam logic [3:0] SRC_SER_B  = 4'hB;
  // Sources with a slot in the vector page start at level 1
  localparam logic [3:0] SRC_FIRST_SLOT = SRC_LEVEL1;
  localparam int NUM_SLOT     = 9;
  localparam int SLOT_IDX_W   = 4;
  // Slot offsets within the page, two bytes per slot
  localparam logic [4:0] OFS_LEVEL1 = 5'h00;
  localparam logic [4:0] OFS_LEVEL2 = 5'h02;
  localparam logic [4:0] OFS_TIMER0 = 5'h04;
  localparam logic [4:0] OFS_TIMER1 = 5'h06;
  localparam logic [4:0] OFS_DMA_A  = 5'h08;
  localparam logic [4:0] OFS_DMA_B  = 5'h0A;
  localparam logic [4:0] OFS_CSIO   = 5'h0C;
  localparam logic [4:0] OFS_SER_A  = 5'h0E;
  localparam logic [4:0] OFS_SER_B  = 5'h10;
  // I/O addresses
  localparam logic [15:0] ADDR_VEC_LOW   = 16'h0033;
  localparam logic [15:0] ADDR_TRAP_CTRL = 16'h0034;
  localparam logic [15:0] ADDR_PAGE_BASE = 16'h0035;
  localparam logic [15:0] ADDR_L0_MODE   = 16'h0036;
  localparam logic [15:0] ADDR_SLOT_BASE = 16'h0040;
  localparam logic [15:0] ADDR_PF_STATE  = 16'hA000;
  // Control register fields and reset values
  localparam int ITC_EN0 = 0;
  localparam int ITC_EN1 = 1;
  localparam int ITC_EN2 = 2;
  localparam logic [7:0] ITC_RESET     = 8'h01;
  localparam logic [7:0] VEC_LOW_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET    = 8'h00;
  localparam int VEC_LOW_MSB = 7;
  localparam int VEC_LOW_LSB = 5;
  // Level 0 response modes
  typedef enum logic [1:0] {
    L0_DEVICE_BYTE, L0_FIXED_RESTART, L0_PAGE_BYTE
  } level0_mode_type;
  // Fixed entry addresses for non-slot responses, and the reset value of every slot
  localparam logic [15:0] TRAP_ENTRY    = 16'h0000;
  localparam logic [15:0] NMI_ENTRY     = 16'h0066;
  localparam logic [15:0] RESTART_ENTRY = 16'h0038;
  localparam logic [15:0] HANDLER_RESET = 16'h0000;
endpackage
`default_nettype wire
